// ### verilog/seg_map_pkg.sv
package seg_map_pkg;
  // address geometry
  localparam int VA_W = 64;
  localparam int PHYSICAL_ADDRESS_WIDTH = 36;
  localparam int SIGN_BIT = 31;
  localparam int EXT_W = VA_W - SIGN_BIT - 1;
  // kernel physical window field layout
  localparam int WIN_TAG_HI = 63;
  localparam int WIN_TAG_LO = 62;
  localparam logic [1:0] WIN_TAG = 2'h2;
  localparam int ATTR_HI = 61;
  localparam int ATTR_LO = 59;
  localparam int ATTR_W = 3;
  localparam int ERRCHK_HI = 58;
  localparam logic [ATTR_W-1:0] ATTR_UNCACHED = 3'h2;
  localparam logic [ATTR_W-1:0] ATTR_NONE = 3'h0;
  // low user segment and debug region bounds
  localparam logic [VA_W-1:0] LOW_USER_TOP = 64'h0000_0000_7FFF_FFFF;
  localparam logic [VA_W-1:0] DEBUG_LO = 64'hFFFF_FFFF_FF20_0000;
  localparam logic [VA_W-1:0] DEBUG_HI = 64'hFFFF_FFFF_FFFF_FFFF;
  // operating mode of a request
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam logic [1:0] MODE_SUPERVISOR = 2'h1;
  localparam logic [1:0] MODE_USER = 2'h2;
  // register map (byte offsets)
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] OFF_STATUS = 8'h04;
  localparam logic [REG_AW-1:0] OFF_MASK = 8'h08;
  localparam logic [REG_AW-1:0] OFF_ERR_LO = 8'h0C;
  localparam logic [REG_AW-1:0] OFF_ERR_HI = 8'h10;
  // control fields
  localparam int CTRL_W = 3;
  localparam int CTRL_ERROR_LEVEL = 0;
  localparam int CTRL_USER_WIDE = 1;
  localparam int CTRL_DEBUG_MODE = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  // event fields, shared by status and mask
  localparam int EV_W = 3;
  localparam int EV_ADDR_ERR = 0;
  localparam int EV_DEBUG_HIT = 1;
  localparam int EV_ERROR_LEVEL = 2;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;
  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_ACTIVE_BIT = 1;
endpackage

// ### verilog/seg_xlat_if.sv
`timescale 1ns/10ps
// carries one request between the top and its two decode helpers
interface seg_xlat_if;
  import seg_map_pkg::*;
  logic [VA_W-1:0] raw_vaddr; // address as the pipeline formed it
  logic is_fetch; // instruction fetch, not data
  logic user_mode; // request made in user mode
  logic user_wide; // user wide address enable
  logic [VA_W-1:0] eff_vaddr; // corrected effective address
  logic win_hit; // address lies in the kernel physical window
  logic win_err; // out-of-range bits set inside the window
  logic [PHYSICAL_ADDRESS_WIDTH-1:0] win_paddr; // window physical address
  logic [ATTR_W-1:0] win_attr; // window cache attribute
  modport ext_mp(input raw_vaddr, is_fetch, user_mode, user_wide, output eff_vaddr);
  modport win_mp(input eff_vaddr, output win_hit, win_err, win_paddr, win_attr);
endinterface

// ### verilog/user_addr_extend.sv
`timescale 1ns/10ps
module user_addr_extend
  import seg_map_pkg::*;
(
  seg_xlat_if.ext_mp xl
);
  // only user data references with narrow addressing get corrected
  wire fix_up;
  assign fix_up = xl.user_mode & ~xl.user_wide & ~xl.is_fetch;
  // copy bit 31 upward; the upper half is discarded, not merged
  assign xl.eff_vaddr = fix_up ?
      {{EXT_W{xl.raw_vaddr[SIGN_BIT]}}, xl.raw_vaddr[SIGN_BIT:0]} : xl.raw_vaddr;
endmodule

// ### verilog/phys_window_decode.sv
`timescale 1ns/10ps
module phys_window_decode
  import seg_map_pkg::*;
(
  seg_xlat_if.win_mp xl
);
  wire [ATTR_W-1:0] attr_field; // attribute straight from the address
  wire range_bad; // bits between attribute and physical width nonzero
  wire win_ok; // in window and in range
  // the eight windows share bits 63:62, the index picks the attribute
  assign xl.win_hit = (xl.eff_vaddr[WIN_TAG_HI:WIN_TAG_LO] == WIN_TAG);
  assign attr_field = xl.eff_vaddr[ATTR_HI:ATTR_LO];
  assign range_bad = |xl.eff_vaddr[ERRCHK_HI:PHYSICAL_ADDRESS_WIDTH];
  assign xl.win_err = xl.win_hit & range_bad;
  assign win_ok = xl.win_hit & ~range_bad;
  // low bits pass through; zero when erroring so nothing leaks out
  assign xl.win_paddr = win_ok ? xl.eff_vaddr[PHYSICAL_ADDRESS_WIDTH-1:0] : '0;
  assign xl.win_attr = win_ok ? attr_field : ATTR_NONE;
endmodule

// ### verilog/unmapped_segment_address_map.sv
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
module unmapped_segment_address_map
  import seg_map_pkg::*;
#(
  parameter bit DEBUG_EXT_PRESENT = 1'b1 // debug extension built in
)
(
  input wire logic clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // request from the load/store and fetch pipeline
  input wire logic req_valid,
  input wire logic [VA_W-1:0] req_vaddr,
  input wire logic req_is_fetch,
  input wire logic [1:0] req_mode,
  // decode answer, one cycle later
  output logic resp_valid,
  output logic [VA_W-1:0] resp_eff_vaddr,
  output logic [PHYSICAL_ADDRESS_WIDTH-1:0] resp_paddr,
  output logic [ATTR_W-1:0] resp_cache_coherency_attribute,
  output logic resp_attr_valid,
  output logic resp_unmapped,
  output logic resp_mapped,
  output logic resp_addr_err,
  output logic resp_debug_region,
  output logic irq
);
  // control and event registers
  logic [CTRL_W-1:0] ctrl; // mode flags written by software
  logic [EV_W-1:0] status; // sticky events
  logic [EV_W-1:0] mask; // interrupt enables
  logic [VA_W-1:0] err_vaddr; // last address that raised an error
  // bus data phase bookkeeping
  logic dp_write; // a write is in its data phase
  logic [REG_AW-1:0] dp_addr; // address of that write

  wire error_level_flag;
  wire user_wide_address_enable;
  wire debug_mode_flag;
  assign error_level_flag = ctrl[CTRL_ERROR_LEVEL];
  assign user_wide_address_enable = ctrl[CTRL_USER_WIDE];
  assign debug_mode_flag = ctrl[CTRL_DEBUG_MODE];

  // shared request bundle for the two decode helpers
  seg_xlat_if xl();
  assign xl.raw_vaddr = req_vaddr;
  assign xl.is_fetch = req_is_fetch;
  assign xl.user_mode = (req_mode == MODE_USER);
  assign xl.user_wide = user_wide_address_enable;

  // user data sign extension
  user_addr_extend u_extend (
    .xl(xl)
  );

  // kernel physical window decode
  phys_window_decode u_window (
    .xl(xl)
  );

  wire [VA_W-1:0] eff;
  assign eff = xl.eff_vaddr;

  wire is_kernel;
  // supervisor references never reach the unmapped paths here
  assign is_kernel = (req_mode == MODE_KERNEL);

  wire in_debug_range;
  assign in_debug_range = (eff >= DEBUG_LO) && (eff <= DEBUG_HI);
  wire dbg_hit;
  assign dbg_hit = DEBUG_EXT_PRESENT && debug_mode_flag && in_debug_range;

  // debug region wins, then the window, then the error level path
  wire win_take;
  assign win_take = ~dbg_hit & is_kernel & xl.win_hit;
  wire low_user;
  assign low_user = (eff <= LOW_USER_TOP);
  wire erl_take;
  assign erl_take = ~dbg_hit & ~win_take & is_kernel & error_level_flag & low_user;

  // next answer values
  wire [PHYSICAL_ADDRESS_WIDTH-1:0] next_paddr;
  wire [ATTR_W-1:0] next_attr;
  wire next_attr_valid;
  wire next_err;
  wire next_mapped;
  assign next_paddr = win_take ? xl.win_paddr :
                      erl_take ? eff[PHYSICAL_ADDRESS_WIDTH-1:0] : '0;
  assign next_attr = win_take ? xl.win_attr : erl_take ? ATTR_UNCACHED : ATTR_NONE;
  assign next_attr_valid = (win_take & ~xl.win_err) | erl_take;
  assign next_err = win_take & xl.win_err;
  // anything else goes on to the tlb and the segment checks outside
  assign next_mapped = ~dbg_hit & ~win_take & ~erl_take;

  // events of this request
  wire [EV_W-1:0] events;
  assign events[EV_ADDR_ERR] = req_valid & next_err;
  assign events[EV_DEBUG_HIT] = req_valid & dbg_hit;
  assign events[EV_ERROR_LEVEL] = req_valid & erl_take;

  // answer valid strobe follows every request by one cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_valid <= 1'b0;
    end else begin
      resp_valid <= req_valid;
    end
  end

  // answer fields hold until the next request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_eff_vaddr <= '0;
      resp_paddr <= '0;
      resp_cache_coherency_attribute <= ATTR_NONE;
      resp_attr_valid <= 1'b0;
      resp_unmapped <= 1'b0;
      resp_mapped <= 1'b0;
      resp_addr_err <= 1'b0;
      resp_debug_region <= 1'b0;
    end else if (req_valid) begin
      resp_eff_vaddr <= eff;
      resp_paddr <= next_paddr;
      resp_cache_coherency_attribute <= next_attr;
      resp_attr_valid <= next_attr_valid;
      resp_unmapped <= next_attr_valid;
      resp_mapped <= next_mapped;
      resp_addr_err <= next_err;
      resp_debug_region <= dbg_hit;
    end
  end

  // bus address phase decode
  wire addr_phase;
  assign addr_phase = hsel & hready & htrans[HTRANS_ACTIVE_BIT];
  // only whole words are written; other sizes are quietly dropped
  wire take_write;
  assign take_write = addr_phase & hwrite & (hsize == HSIZE_WORD);
  wire take_read;
  assign take_read = addr_phase & ~hwrite;

  // remember a write for its data phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dp_write <= 1'b0;
      dp_addr <= '0;
    end else if (hready) begin
      dp_write <= take_write;
      dp_addr <= haddr[REG_AW-1:0];
    end
  end

  // data phase write strobes, unmapped offsets hit nothing
  wire wr_ctrl;
  wire wr_status;
  wire wr_mask;
  assign wr_ctrl = dp_write & (dp_addr == OFF_CTRL);
  assign wr_status = dp_write & (dp_addr == OFF_STATUS);
  assign wr_mask = dp_write & (dp_addr == OFF_MASK);

  // control register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= hwdata[CTRL_W-1:0];
    end
  end

  // mask register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask <= EV_RESET;
    end else if (wr_mask) begin
      mask <= hwdata[EV_W-1:0];
    end
  end

  // write-one-to-clear; a new event in the same cycle keeps its bit
  wire [EV_W-1:0] clear_bits;
  wire [EV_W-1:0] next_status;
  assign clear_bits = wr_status ? hwdata[EV_W-1:0] : '0;
  assign next_status = (status & ~clear_bits) | events;

  // sticky status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= EV_RESET;
    end else begin
      status <= next_status;
    end
  end

  // error address capture for the handler
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_vaddr <= '0;
    end else if (events[EV_ADDR_ERR]) begin
      err_vaddr <= eff;
    end
  end

  // level interrupt from any unmasked sticky bit
  assign irq = |(status & mask);

  // read mux on the address phase; zero for unmapped offsets
  wire [REG_AW-1:0] ra;
  wire [31:0] rd_word;
  assign ra = haddr[REG_AW-1:0];
  assign rd_word = (ra == OFF_CTRL) ? {{(32-CTRL_W){1'b0}}, ctrl} :
                   (ra == OFF_STATUS) ? {{(32-EV_W){1'b0}}, status} :
                   (ra == OFF_MASK) ? {{(32-EV_W){1'b0}}, mask} :
                   (ra == OFF_ERR_LO) ? err_vaddr[31:0] :
                   (ra == OFF_ERR_HI) ? err_vaddr[VA_W-1:32] : 32'h0000_0000;

  // read data latched at the address phase, so it stands through the
  // data phase; a write whose data phase overlaps is not yet visible
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (take_read) begin
      hrdata <= rd_word;
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // outside code keeps privileged narrow addresses sign-extended
  // such addresses are decoded as given with no repair

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // answers are judged one edge after their request, when status has moved too

  AST_WIN_BASE_ZERO: assert property (
    resp_valid && resp_attr_valid && resp_eff_vaddr[63:59] == 5'h10
    |-> resp_cache_coherency_attribute == 3'h0 &&
        resp_paddr == resp_eff_vaddr[PHYSICAL_ADDRESS_WIDTH-1:0])
    else $error("base window attribute or address wrong");

  AST_WIN_BASE_SEVEN: assert property (
    req_valid && req_mode == MODE_KERNEL && req_vaddr[63:59] == 5'h17 &&
    req_vaddr[58:36] == 23'h000000
    |=> resp_unmapped && !resp_mapped && resp_cache_coherency_attribute == 3'h7)
    else $error("top window not attribute seven");

  AST_WIN_UNCACHED: assert property (
    req_valid && req_mode == MODE_KERNEL && req_vaddr[63:59] == 5'h12 &&
    req_vaddr[58:36] == 23'h000000
    |=> resp_attr_valid && resp_cache_coherency_attribute == ATTR_UNCACHED)
    else $error("uncached window not attribute two");

  AST_WIN_RANGE_ERR: assert property (
    req_valid && req_mode == MODE_KERNEL && req_vaddr[63:62] == 2'h2 &&
    req_vaddr[58:36] != 23'h000000
    |=> resp_addr_err && !resp_attr_valid && resp_paddr == '0 && status[EV_ADDR_ERR])
    else $error("window range error missed");

  AST_WIN_ATTR_FIELD: assert property (
    resp_valid && resp_attr_valid && resp_eff_vaddr[63:62] == 2'h2
    |-> resp_cache_coherency_attribute == resp_eff_vaddr[61:59])
    else $error("attribute not from bits 61:59");

  AST_ERL_UNMAPPED: assert property (
    req_valid && req_mode == MODE_KERNEL && error_level_flag &&
    req_vaddr <= LOW_USER_TOP
    |=> resp_unmapped && !resp_mapped && resp_cache_coherency_attribute == ATTR_UNCACHED)
    else $error("error level low user not unmapped");

  AST_ERL_BOUND: assert property (
    req_valid && req_mode == MODE_KERNEL && req_vaddr == 64'h0000_0000_8000_0000
    |=> !resp_unmapped && resp_mapped)
    else $error("error level path beyond low user top");

  AST_ERL_DIRECT: assert property (
    resp_valid && resp_unmapped && resp_eff_vaddr <= LOW_USER_TOP
    |-> resp_paddr == resp_eff_vaddr[PHYSICAL_ADDRESS_WIDTH-1:0])
    else $error("error level address offset applied");

  AST_DEBUG_HIT: assert property (
    resp_valid && $past(debug_mode_flag)
    |-> resp_debug_region == (DEBUG_EXT_PRESENT && resp_eff_vaddr >= DEBUG_LO))
    else $error("debug region bounds wrong");

  AST_DEBUG_OFF: assert property (
    resp_valid && !$past(debug_mode_flag) |-> !resp_debug_region)
    else $error("debug region active outside debug mode");

  AST_DEBUG_STICKY: assert property (
    events[EV_DEBUG_HIT] |=> status[EV_DEBUG_HIT])
    else $error("debug region hit not recorded");

  AST_USER_SIGN_EXT: assert property (
    req_valid && req_mode == MODE_USER && !user_wide_address_enable && !req_is_fetch
    |=> resp_eff_vaddr[63:32] == {32{resp_eff_vaddr[31]}} &&
        resp_eff_vaddr[SIGN_BIT:0] == $past(req_vaddr[SIGN_BIT:0]))
    else $error("user data address not sign extended");

  AST_EXT_BEFORE_CHECK: assert property (
    req_valid && req_mode == MODE_USER && !user_wide_address_enable && !req_is_fetch &&
    DEBUG_EXT_PRESENT && debug_mode_flag && req_vaddr[SIGN_BIT:0] >= DEBUG_LO[SIGN_BIT:0]
    |=> resp_debug_region && resp_eff_vaddr >= DEBUG_LO)
    else $error("region check used the uncorrected address");

  AST_FETCH_RAW: assert property (
    req_valid && req_is_fetch |=> resp_eff_vaddr == $past(req_vaddr))
    else $error("fetch address was altered");

  COV_WINDOW: cover property (resp_valid && resp_attr_valid && !resp_eff_vaddr[62]);
  COV_ERL: cover property (events[EV_ERROR_LEVEL] ##1 resp_unmapped);
  COV_DEBUG: cover property (events[EV_DEBUG_HIT] ##[1:3] irq);
  COV_ERR: cover property (events[EV_ADDR_ERR] ##1 resp_addr_err);
endmodule

// ### verif/pipe_model.sv
`timescale 1ns/10ps
// load/store and fetch pipeline as seen by the decoder
module pipe_model
  import seg_map_pkg::*;
(
  input wire logic clk,
  output logic req_valid,
  output logic [VA_W-1:0] req_vaddr,
  output logic req_is_fetch,
  output logic [1:0] req_mode
);
  // quiet outputs at time zero
  initial begin
    req_valid = 1'b0;
    req_vaddr = '0;
    req_is_fetch = 1'b0;
    req_mode = MODE_KERNEL;
  end
  // one request per call, back to back when called again at once
  // privileged addresses passed as formed
  task issue(input logic [VA_W-1:0] va, input logic f, input logic [1:0] m);
    @(posedge clk);
    req_valid <= 1'b1;
    req_vaddr <= va;
    req_is_fetch <= f;
    req_mode <= m;
  endtask
  // drop the strobe; address and fetch lines scrambled so a stale value cannot pass
  task rest;
    @(posedge clk);
    req_valid <= 1'b0;
    req_vaddr <= ~req_vaddr;
    req_is_fetch <= ~req_is_fetch;
  endtask
endmodule

// ### verif/unmapped_segment_address_map_tb.sv
`timescale 1ns/10ps
module unmapped_segment_address_map_tb;
  import seg_map_pkg::*;
  // one decode answer, packed in port order
  typedef struct packed {
    logic [VA_W-1:0] eff;
    logic [PHYSICAL_ADDRESS_WIDTH-1:0] pa;
    logic [ATTR_W-1:0] attr;
    logic av, um, mp, err, dbg;
  } exp_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, req_mode;
  logic [2:0] hsize;
  logic req_valid, req_is_fetch, resp_valid, resp_attr_valid, resp_unmapped;
  logic resp_mapped, resp_addr_err, resp_debug_region;
  logic [VA_W-1:0] req_vaddr, resp_eff_vaddr, va, va_err;
  logic [PHYSICAL_ADDRESS_WIDTH-1:0] resp_paddr;
  logic [ATTR_W-1:0] resp_attr;
  logic [CTRL_W-1:0] ctrl_s; // shadow of the control register
  exp_t expq[$]; // answers still owed by the design
  int bad_count = 0;
  int n_checks = 0;
  integer seed = 32'hbf475a23;
  int i, j;
  always #10 clk = ~clk;
  assign hready = hreadyout;
  pipe_model u_pipe (.clk(clk), .req_valid(req_valid), .req_vaddr(req_vaddr),
    .req_is_fetch(req_is_fetch), .req_mode(req_mode));
  unmapped_segment_address_map dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .req_valid(req_valid),
    .req_vaddr(req_vaddr), .req_is_fetch(req_is_fetch), .req_mode(req_mode),
    .resp_valid(resp_valid), .resp_eff_vaddr(resp_eff_vaddr), .resp_paddr(resp_paddr),
    .resp_cache_coherency_attribute(resp_attr), .resp_attr_valid(resp_attr_valid),
    .resp_unmapped(resp_unmapped), .resp_mapped(resp_mapped), .resp_addr_err(resp_addr_err),
    .resp_debug_region(resp_debug_region), .irq(irq));
  // verdict, reached from the main sequence and from every timeout
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task cmp_resp(input exp_t g, input exp_t e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cmp_reg(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // expected decode, priority debug, window, error level, mapped
  function automatic exp_t predict(logic [VA_W-1:0] a, logic f, logic [1:0] m);
    exp_t e;
    logic [VA_W-1:0] x;
    x = (m == MODE_USER && !ctrl_s[CTRL_USER_WIDE] && !f) ? {{32{a[31]}}, a[31:0]} : a;
    e = '0;
    e.eff = x;
    if (ctrl_s[CTRL_DEBUG_MODE] && x >= DEBUG_LO && x <= DEBUG_HI) begin
      e.dbg = 1'b1;
    end else if (m == MODE_KERNEL && x[WIN_TAG_HI:WIN_TAG_LO] == WIN_TAG) begin
      if (x[ERRCHK_HI:PHYSICAL_ADDRESS_WIDTH] != '0) begin
        e.err = 1'b1;
      end else begin
        e.pa = x[PHYSICAL_ADDRESS_WIDTH-1:0];
        e.attr = x[ATTR_HI:ATTR_LO];
        e.av = 1'b1;
        e.um = 1'b1;
      end
    end else if (m == MODE_KERNEL && ctrl_s[CTRL_ERROR_LEVEL] && x <= LOW_USER_TOP) begin
      e.pa = x[PHYSICAL_ADDRESS_WIDTH-1:0];
      e.attr = ATTR_UNCACHED;
      e.av = 1'b1;
      e.um = 1'b1;
    end else begin
      e.mp = 1'b1;
    end
    return e;
  endfunction
  // waits for hready at a rising edge, bounded
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      bad_count++;
      stop_test;
    end
  endtask
  // one single word transfer: address phase, then data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= HSIZE_WORD;
    wait_rdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy;
    r = hrdata;
    cmp_reg({31'h0, hresp}, 32'h0);
  endtask
  task bus_wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  task reg_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd);
    cmp_reg(rd, e);
  endtask
  // irq is looked at once the last write has landed
  task irq_chk(input logic e);
    @(negedge clk);
    cmp_reg({31'h0, irq}, {31'h0, e});
  endtask
  // request through the pipeline, expectation noted, random gap
  task send(input logic [VA_W-1:0] a, input logic f, input logic [1:0] m);
    u_pipe.issue(a, f, m);
    expq.push_back(predict(a, f, m));
    if ($random(seed) & 1)
      u_pipe.rest();
  endtask
  // stop requests and wait until every answer has been seen
  task flush;
    int n;
    u_pipe.rest();
    n = 0;
    while (expq.size() != 0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (expq.size() != 0) begin
      bad_count++;
      stop_test;
    end
  endtask
  // answer watcher, off the launching edge
  always @(negedge clk) begin
    if (resp_valid === 1'b1) begin
      if (expq.size() == 0) begin
        bad_count++;
        $display("BAD %0t got %h exp %h", $time, resp_eff_vaddr, 64'h0);
      end else begin
        cmp_resp({resp_eff_vaddr, resp_paddr, resp_attr, resp_attr_valid, resp_unmapped,
          resp_mapped, resp_addr_err, resp_debug_region}, expq.pop_front());
      end
    end
  end
  // hang guard
  initial begin
    repeat (50000) @(posedge clk);
    bad_count++;
    stop_test;
  end
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    ctrl_s = CTRL_RESET;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // reset values, last offset is unmapped
    for (i = 0; i < 6; i++)
      reg_chk(8'(4 * i), 32'h0);
    irq_chk(1'b0);
    $display("test reset done");
    // every window attribute, then both ends of the error field
    for (i = 0; i < 8; i++)
      send({WIN_TAG, 3'(i), 23'h0, 36'({$random(seed), $random(seed)})}, 1'b0, MODE_KERNEL);
    send({WIN_TAG, 3'h7, 23'h1, 36'h0}, 1'b0, MODE_KERNEL);
    va_err = {WIN_TAG, 3'h5, 23'h400000, 36'h0};
    send(va_err, 1'b0, MODE_KERNEL);
    send({WIN_TAG, 3'h2, 23'h0, 36'h1000}, 1'b0, MODE_SUPERVISOR);
    flush;
    reg_chk(OFF_STATUS, 32'h1);
    reg_chk(OFF_ERR_LO, va_err[31:0]);
    reg_chk(OFF_ERR_HI, va_err[63:32]);
    bus_wr(OFF_MASK, 32'h1);
    irq_chk(1'b1);
    bus_wr(OFF_STATUS, 32'h1);
    irq_chk(1'b0);
    $display("test window done");
    // error level: low user segment unmapped and uncached in kernel mode
    ctrl_s = 3'h1;
    bus_wr(OFF_CTRL, 32'h1);
    send(LOW_USER_TOP, 1'b0, MODE_KERNEL);
    send(LOW_USER_TOP + 64'h1, 1'b0, MODE_KERNEL);
    send(64'h0, 1'b1, MODE_KERNEL);
    send({33'h0, 31'($random(seed))}, 1'b0, MODE_KERNEL);
    send(LOW_USER_TOP, 1'b0, MODE_SUPERVISOR);
    flush;
    reg_chk(OFF_STATUS, 32'h4);
    irq_chk(1'b0);
    $display("test error level done");
    // debug region bounds, only while the debug flag is set
    ctrl_s = 3'h4;
    bus_wr(OFF_CTRL, 32'h4);
    send(DEBUG_LO, 1'b0, MODE_KERNEL);
    send(DEBUG_LO - 64'h1, 1'b0, MODE_KERNEL);
    send(DEBUG_HI, 1'b1, MODE_USER);
    send({32'h0, DEBUG_LO[31:0]}, 1'b0, MODE_USER);
    flush;
    ctrl_s = 3'h0;
    bus_wr(OFF_CTRL, 32'h0);
    send(DEBUG_LO, 1'b0, MODE_KERNEL);
    flush;
    reg_chk(OFF_STATUS, 32'h6);
    bus_wr(OFF_MASK, 32'h6);
    irq_chk(1'b1);
    bus_wr(OFF_STATUS, 32'h6);
    irq_chk(1'b0);
    reg_chk(OFF_STATUS, 32'h0);
    $display("test debug done");
    // mid-run reset brings control, mask and error address high back to zero
    bus_wr(OFF_CTRL, 32'h5);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    ctrl_s = CTRL_RESET;
    reg_chk(OFF_CTRL, 32'h0);
    reg_chk(OFF_MASK, 32'h0);
    reg_chk(OFF_ERR_HI, 32'h0);
    $display("test mid reset done");
    // user address correction with the wide enable off and on
    for (i = 0; i < 2; i++) begin
      ctrl_s = 3'(2 * i);
      bus_wr(OFF_CTRL, 32'(2 * i));
      send(64'hFFFF_FFFF_7FFF_FFFC, 1'b0, MODE_USER);
      for (j = 0; j < 6; j++) begin
        va = {$random(seed), $random(seed)};
        send(va, 1'b0, MODE_USER);
        send(va, 1'b1, MODE_USER);
        send(va, 1'b0, MODE_KERNEL);
      end
      flush;
    end
    $display("test user extension done");
    stop_test;
  end
endmodule
